// ### serial_peer.sv
// Purpose: Remote serial peer decoding frames on the transmit pin
// Assumes: Bit time and slot count set by the bench
// Notes:   Holds the shared line low while talk_i is high
module serial_peer (
  input  wire logic   clk_i,
  input  wire logic   line_i,
  input  wire logic   oe_i,
  input  wire logic   talk_i,
  input  var int      bit_cyc_i,
  input  var int      nbits_i,
  output logic        line_o,
  output logic [8:0]  word_o,
  output int          frames_o,
  output int          gap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int   now = 0;
  int   last = 0;
  logic ok;
  assign line_o = !talk_i;
  always @(posedge clk_i) now <= now + 1;
  // ==========================================================
  // Frame capture
  initial begin
    frames_o = 0;
    forever begin
      @(posedge clk_i);
      if (oe_i && !line_i) begin
        gap_o = now - last;
        last = now;
        word_o = 9'h000;
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        ok = !line_i;
        for (int i = 0; i < nbits_i; i++) begin
          repeat (bit_cyc_i) @(posedge clk_i);
          word_o[i] = line_i;
          ok = ok & oe_i;
        end
        repeat (bit_cyc_i) @(posedge clk_i);
        if (ok && oe_i && line_i) frames_o++;
      end
    end
  end
endmodule : serial_peer

// ### tb.sv
// Purpose: Self-checking bench for the serial port core
// Assumes: One clock at 10 MHz, peer decodes the transmit pin
// Notes:   Frame format table walked with back-to-back frames
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_i, rst_i, read_i, write_i, talk, peer_line, rxtx_w;
  logic              waitrequest_o, tx_pin_o, tx_pin_oe_o, rxtx_o, rxtx_oe_o, rx_line_o;
  logic [4:0]        address_i;
  logic [3:0]        byteenable_i;
  logic [31:0]       writedata_i, readdata_o, q;
  logic [8:0]        word;
  logic [7:0]        c1[7], c2[7], dv[7], dt[7];
  logic [8:0]        wd[7];
  uart_pkg::rx_evt_s rx_evt;
  int                frames, gap, bit_cyc, nbits, num_errors, checks, f0, e;
  assign rxtx_w = rxtx_oe_o ? rxtx_o : peer_line;
  uart_core #(.DIV_W(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .rx_evt_i(rx_evt),
    .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o), .rxtx_i(rxtx_w), .rxtx_o(rxtx_o),
    .rxtx_oe_o(rxtx_oe_o), .rx_line_o(rx_line_o));
  serial_peer PEER (
    .clk_i(clk_i), .line_i(tx_pin_o), .oe_i(tx_pin_oe_o), .talk_i(talk),
    .bit_cyc_i(bit_cyc), .nbits_i(nbits), .line_o(peer_line), .word_o(word),
    .frames_o(frames), .gap_o(gap));
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= {24'h000000, d};
    byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    if (waitrequest_o !== 1'b0) begin
      num_errors++;
      give_verdict();
    end
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(what, q, {24'h000000, exp});
  endtask : rd
  task automatic send(input logic [7:0] d);
    bus(1'b0, uart_pkg::STATUS_OFS, 8'h00, 4'hf);
    wr(uart_pkg::DATA_OFS, d);
  endtask : send
  task automatic waitf(input int n);
    int k;
    k = 0;
    while (frames < n && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    if (frames < n) begin
      num_errors++;
      give_verdict();
    end
  endtask : waitf
  // ==========================================================
  // Stimulus
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, read_i, write_i, address_i, writedata_i, byteenable_i} = {1'b1, 43'h0};
    rx_evt = 6'h00;
    talk = 1'b0;
    bit_cyc = 16;
    nbits = 8;
    c1 = '{8'h80, 8'hc1, 8'ha0, 8'hb8, 8'he0, 8'h80, 8'h80};
    c2 = '{8'he0, 8'hf0, 8'he0, 8'he0, 8'he0, 8'hc0, 8'he0};
    dv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
    dt = '{8'ha5, 8'h3c, 8'h07, 8'h03, 8'hff, 8'h5a, 8'h96};
    wd = '{9'h0a5, 9'h13c, 9'h087, 9'h083, 9'h0ff, 9'h05a, 9'h096};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(uart_pkg::CTRL_ONE_OFS, 8'h00, "ctrl one"); // Format 8N1
    rd(uart_pkg::CTRL_THREE_OFS, 8'h00, "ctrl three"); // Reset
    rd(uart_pkg::DIVISOR_OFS, uart_pkg::DIVISOR_RST, "divisor"); // Reset
    rd(uart_pkg::STATUS_OFS, 8'hd0, "status"); // Idle flags
    wr(5'h18, 8'hff);
    rd(5'h18, 8'h00, "unmapped"); // Hidden shifter
    wr(uart_pkg::DIVISOR_OFS, 8'hff);
    bus(1'b1, uart_pkg::DIVISOR_OFS, 8'h7f, 4'he);
    rd(uart_pkg::DIVISOR_OFS, 8'hff, "divisor max"); // Full range
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(uart_pkg::DIVISOR_OFS, dv[i]);
      wr(uart_pkg::CTRL_ONE_OFS, c1[i]);
      wr(uart_pkg::CTRL_TWO_OFS, c2[i]);
      bit_cyc = (c2[i][5] ? 16 : 64) * (dv[i] + 1);
      nbits = c1[i][6] ? 9 : 8;
      e = bit_cyc * (nbits + (c1[i][3] ? 3 : 2)) + 1;
      f0 = frames;
      send(dt[i]);
      send(dt[i]);
      bus(1'b0, uart_pkg::STATUS_OFS, 8'h00, 4'hf);
      chk("busy flags", q & 32'hc0, 32'h0); // Flags cleared
      send(8'h00);
      rd(uart_pkg::DATA_OFS, dt[i], "data kept"); // Write ignored
      waitf(f0 + 2);
      chk("word", {23'h0, word}, {23'h0, wd[i]}); // Bits and parity
      chk("gap", {31'h0, gap >= e && gap <= e + 2}, 32'h1); // Bit time
      repeat (bit_cyc * 4) @(posedge clk_i);
      chk("frames", 32'(frames), 32'(f0 + 2)); // No extra frame
    end
    $display("test formats done");
    f0 = frames;
    send(8'h55);
    repeat (100) @(posedge clk_i);
    wr(uart_pkg::CTRL_TWO_OFS, 8'h60);
    repeat (2) @(posedge clk_i);
    chk("tx pin", {30'h0, tx_pin_oe_o, tx_pin_o}, 32'h1); // Abort frame
    repeat (bit_cyc * 12) @(posedge clk_i);
    chk("frames", 32'(frames), 32'(f0)); // Frame lost
    send(8'h69);
    wr(uart_pkg::CTRL_TWO_OFS, 8'he0);
    waitf(f0 + 1);
    chk("late start", {23'h0, word}, 32'h69); // Data then enable
    $display("test tx enable done");
    talk <= 1'b1;
    rx_evt <= 6'h1f;
    @(posedge clk_i);
    rx_evt <= 6'h00;
    repeat (3) @(posedge clk_i);
    chk("rx line", {31'h0, rx_line_o}, 32'h0); // Shared input
    bus(1'b0, uart_pkg::STATUS_OFS, 8'h00, 4'hf);
    chk("rx flags", q & 32'h2f, 32'h2f); // Sticky errors
    f0 = frames;
    send(8'h11);
    send(8'h22);
    repeat (100) @(posedge clk_i);
    wr(uart_pkg::CTRL_ONE_OFS, 8'h38);
    repeat (3) @(posedge clk_i);
    chk("pins", {28'h0, tx_pin_oe_o, tx_pin_o, rxtx_oe_o, rx_line_o}, 32'h5);
    rd(uart_pkg::CTRL_ONE_OFS, 8'h38, "ctrl one"); // Kept
    rd(uart_pkg::CTRL_TWO_OFS, 8'h20, "ctrl two"); // Enables off
    rd(uart_pkg::DIVISOR_OFS, 8'h02, "divisor"); // Kept
    rd(uart_pkg::STATUS_OFS, 8'hd0, "status"); // Flags reset
    talk <= 1'b0;
    wr(uart_pkg::CTRL_ONE_OFS, 8'h80);
    wr(uart_pkg::CTRL_TWO_OFS, 8'he0);
    repeat (bit_cyc * 24) @(posedge clk_i);
    chk("frames", 32'(frames), 32'(f0)); // Buffer emptied
    $display("test disable done");
    give_verdict();
  end
endmodule : tb

// ### uart_core.sv
// Purpose: Serial port core: baud generator, frame format, enable, transmitter
// Assumes: Avalon-MM slave, waitrequest one cycle, inputs synchronous
// Notes:   Receiver recovery lives outside; its events arrive on rx_evt_i
//
// Operation
// - Bit time is 64 or 16 times (N+1)
// - 8-bit timer restarted at each load, divisor 0 to 255
// - NRZ frame: start, 8/9 bits with parity as the last, stop_count_sel
// - Power-on format is 8, none, 1
// - Data goes out least significant bit first
// - One format and baud for both directions
// - Enabled: drive transmit pin, idle high
// - Master disable releases both serial pins
// - Disable empties the data buffer
// - Disable clears enables, errors; sets idle flags
// - Disable keeps other control except break, and divisor
// - Disable aborts any frame at once
// - Nine-bit mode takes MSB from ninth bit when parity is off
// - Parity on/off, odd/even, one/two stop_count_sel
// - MSB marks address frame when detect enabled
// - Two stop_count_sel only on transmit side
// - Shifter reloads only after stop bits
// - Shift register is not software visible
// - Start needs enable, data and baud clocks
// - Idle shifter takes written data directly
// - Transmit disable aborts frame, releases pin
// - Status read then data write clears flags
// - Data writes ignored while empty flag low
module uart_core #(
  parameter int DIV_W = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic [4:0]            address_i,
  input  wire logic                  read_i,
  input  wire logic                  write_i,
  input  wire logic [31:0]           writedata_i,
  input  wire logic [3:0]            byteenable_i,
  output logic      [31:0]           readdata_o,
  output logic                       waitrequest_o,
  input  wire uart_pkg::rx_evt_s     rx_evt_i,
  output logic                       tx_pin_o,
  output logic                       tx_pin_oe_o,
  input  wire logic                  rxtx_i,
  output logic                       rxtx_o,
  output logic                       rxtx_oe_o,
  output logic                       rx_line_o
);

  // ==========================================================
  // Elaboration check
  if (DIV_W < 1 || DIV_W > 8) begin : g_chk
    $error("DIV_W must lie between 1 and 8");
  end

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_state_e;

  logic             ack_reg;
  logic             take;
  logic             wr;
  logic             rd;
  logic [31:0]      readdata_reg;
  logic [7:0]       rd_mux;
  logic             master_en_reg;
  logic             break_reg;
  logic             ninth_reg;
  logic             tx_en_reg;
  logic             rx_en_reg;
  logic             high_spd_reg;
  logic             single_wire_reg;
  uart_pkg::fmt_s   fmt_reg;
  logic [DIV_W-1:0] divisor_reg;
  logic [DIV_W-1:0] baud_tmr_reg;
  logic [5:0]       sub_reg;
  logic [5:0]       sub_max;
  logic             tick;
  logic             bit_end;
  logic [7:0]       buf_reg;
  logic             buf_full_reg;
  logic             tx_empty_reg;
  logic             tx_idle_reg;
  logic             armed_reg;
  logic [5:0]       rx_flags_reg;
  logic             rx_idle_reg;
  logic             rx_line_reg;
  tx_state_e        tx_state_reg;
  logic [8:0]       tx_shift_reg;
  logic [3:0]       cnt_reg;
  logic [3:0]       nbits;
  logic             line_reg;
  logic             oe_reg;
  logic             tx_on;
  logic             load;
  logic             frame_done;
  logic             data_wr;

  // ==========================================================
  // Avalon slave: one wait cycle, then registered answer
  assign waitrequest_o = (read_i | write_i) & ~ack_reg;
  assign take          = (read_i | write_i) & ack_reg;
  assign wr            = write_i & take & byteenable_i[0];
  assign rd            = read_i & take;
  assign readdata_o    = readdata_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= (read_i | write_i) & ~ack_reg;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (address_i)
      uart_pkg::CTRL_ONE_OFS: begin
        rd_mux[uart_pkg::MASTER_EN_BIT] = master_en_reg;
        rd_mux[uart_pkg::WORD_LEN_BIT]  = fmt_reg.word9;
        rd_mux[uart_pkg::PAR_EN_BIT]    = fmt_reg.par_en;
        rd_mux[uart_pkg::PAR_TYPE_BIT]  = fmt_reg.par_odd;
        rd_mux[uart_pkg::STOP_CNT_BIT]  = fmt_reg.stop2;
        rd_mux[uart_pkg::BREAK_BIT]     = break_reg;
      end
      uart_pkg::CTRL_TWO_OFS: begin
        rd_mux[uart_pkg::TX_EN_BIT]    = tx_en_reg;
        rd_mux[uart_pkg::RX_EN_BIT]    = rx_en_reg;
        rd_mux[uart_pkg::HIGH_SPD_BIT] = high_spd_reg;
        rd_mux[uart_pkg::ADDR_EN_BIT]  = fmt_reg.addr_en;
      end
      uart_pkg::CTRL_THREE_OFS: begin
        rd_mux[uart_pkg::SINGLE_WIRE_BIT] = single_wire_reg;
      end
      uart_pkg::DIVISOR_OFS: begin
        rd_mux[DIV_W-1:0] = divisor_reg;
      end
      uart_pkg::DATA_OFS: begin
        rd_mux = buf_reg;
      end
      uart_pkg::STATUS_OFS: begin
        rd_mux[5:0] = rx_flags_reg;
        rd_mux[uart_pkg::ST_RX_IDLE]  = rx_idle_reg;
        rd_mux[uart_pkg::ST_TX_IDLE]  = tx_idle_reg;
        rd_mux[uart_pkg::ST_TX_EMPTY] = tx_empty_reg;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (ce_i && (read_i | write_i) && !ack_reg) begin
      readdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Control registers
  // Power-on format
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_en_reg <= 1'b0;
      fmt_reg       <= '0;
      break_reg     <= 1'b0;
      ninth_reg     <= 1'b0;
    end else if (ce_i) begin
      if (wr && address_i == uart_pkg::CTRL_ONE_OFS) begin
        master_en_reg <= writedata_i[uart_pkg::MASTER_EN_BIT];
        fmt_reg.word9 <= writedata_i[uart_pkg::WORD_LEN_BIT];
        fmt_reg.par_en <= writedata_i[uart_pkg::PAR_EN_BIT];
        fmt_reg.par_odd <= writedata_i[uart_pkg::PAR_TYPE_BIT];
        fmt_reg.stop2 <= writedata_i[uart_pkg::STOP_CNT_BIT];
        break_reg     <= writedata_i[uart_pkg::BREAK_BIT];
        ninth_reg     <= writedata_i[uart_pkg::NINTH_BIT];
      end else if (!master_en_reg) begin
        break_reg <= 1'b0;
      end
      if (wr && address_i == uart_pkg::CTRL_TWO_OFS) begin
        fmt_reg.addr_en <= writedata_i[uart_pkg::ADDR_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_en_reg       <= 1'b0;
      rx_en_reg       <= 1'b0;
      high_spd_reg    <= 1'b0;
      single_wire_reg <= 1'b0;
      divisor_reg     <= uart_pkg::DIVISOR_RST[DIV_W-1:0];
    end else if (ce_i) begin
      if (wr && address_i == uart_pkg::CTRL_TWO_OFS) begin
        tx_en_reg    <= writedata_i[uart_pkg::TX_EN_BIT] & master_en_reg;
        rx_en_reg    <= writedata_i[uart_pkg::RX_EN_BIT] & master_en_reg;
        high_spd_reg <= writedata_i[uart_pkg::HIGH_SPD_BIT];
      end else if (!master_en_reg) begin
        tx_en_reg <= 1'b0;
        rx_en_reg <= 1'b0;
      end
      if (wr && address_i == uart_pkg::CTRL_THREE_OFS) begin
        single_wire_reg <= writedata_i[uart_pkg::SINGLE_WIRE_BIT];
      end
      if (wr && address_i == uart_pkg::DIVISOR_OFS) begin
        divisor_reg <= writedata_i[DIV_W-1:0];
      end
    end
  end

  // ==========================================================
  // Baud generator
  assign tx_on = master_en_reg & tx_en_reg;
  assign load  = tx_on && tx_state_reg == TX_IDLE && buf_full_reg;
  assign tick  = baud_tmr_reg == '0;
  assign sub_max = high_spd_reg ? uart_pkg::SUB_HIGH_MAX : uart_pkg::SUB_LOW_MAX;
  assign bit_end = tick && sub_reg == sub_max;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_tmr_reg <= '0;
      sub_reg      <= 6'h00;
    end else if (ce_i) begin
      if (!master_en_reg || load) begin
        baud_tmr_reg <= divisor_reg;
        sub_reg      <= 6'h00;
      end else if (tick) begin
        baud_tmr_reg <= divisor_reg;
        sub_reg      <= (sub_reg == sub_max) ? 6'h00 : sub_reg + 6'h01;
      end else begin
        baud_tmr_reg <= baud_tmr_reg - 1'b1;
      end
    end
  end

  // ==========================================================
  // Frame word: ninth bit, parity slot
  // One format for both directions
  assign nbits = fmt_reg.word9 ? uart_pkg::BITS_NINE : uart_pkg::BITS_EIGHT;

  function automatic logic [8:0] frame_word(input logic [7:0] d,
                                            input logic ninth,
                                            input uart_pkg::fmt_s f);
    logic [8:0] w;
    logic       p;
    w = {ninth, d};
    if (!f.word9) begin
      w[8] = 1'b0;
    end
    if (f.word9) begin
      p = ^w[7:0];
    end else begin
      p = ^w[6:0];
    end
    if (f.par_en) begin
      if (f.word9) begin
        w[8] = p ^ f.par_odd;
      end else begin
        w[7] = p ^ f.par_odd;
      end
    end
    return w;
  endfunction : frame_word

  // ==========================================================
  // Transmit buffer and flags
  // Writes need empty flag
  assign data_wr = wr && address_i == uart_pkg::DATA_OFS && tx_empty_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_reg      <= 8'h00;
      buf_full_reg <= 1'b0;
    end else if (ce_i) begin
      if (!master_en_reg) begin
        buf_reg      <= 8'h00;
        buf_full_reg <= 1'b0;
      end else if (data_wr) begin
        buf_reg      <= writedata_i[7:0];
        buf_full_reg <= 1'b1;
      end else if (load) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (rd && address_i == uart_pkg::STATUS_OFS) begin
        armed_reg <= 1'b1;
      end else if (data_wr || !master_en_reg) begin
        armed_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_empty_reg <= uart_pkg::FLAG_SET_RST;
    end else if (ce_i) begin
      if (!master_en_reg || load) begin
        tx_empty_reg <= 1'b1;
      end else if (data_wr && armed_reg) begin
        tx_empty_reg <= 1'b0;
      end
    end
  end

  // Idle set on disable or frame end with buffer empty
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_idle_reg <= uart_pkg::FLAG_SET_RST;
    end else if (ce_i) begin
      if (!master_en_reg || (frame_done && !buf_full_reg)) begin
        tx_idle_reg <= 1'b1;
      end else if (data_wr && armed_reg) begin
        tx_idle_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive-side flags from the external recovery logic
  // Receive flags cleared on disable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_flags_reg <= 6'h00;
      rx_idle_reg  <= uart_pkg::FLAG_SET_RST;
      rx_line_reg  <= 1'b1;
    end else if (ce_i) begin
      if (!master_en_reg || !rx_en_reg) begin
        rx_flags_reg <= 6'h00;
        rx_idle_reg  <= 1'b1;
        rx_line_reg  <= 1'b1;
      end else begin
        rx_flags_reg[uart_pkg::ST_PARITY]   <= rx_flags_reg[uart_pkg::ST_PARITY]
                                               | rx_evt_i.parity;
        rx_flags_reg[uart_pkg::ST_NOISE]    <= rx_flags_reg[uart_pkg::ST_NOISE]
                                               | rx_evt_i.noise;
        rx_flags_reg[uart_pkg::ST_FRAMING]  <= rx_flags_reg[uart_pkg::ST_FRAMING]
                                               | rx_evt_i.framing;
        rx_flags_reg[uart_pkg::ST_OVERRUN]  <= rx_flags_reg[uart_pkg::ST_OVERRUN]
                                               | rx_evt_i.overrun;
        rx_flags_reg[uart_pkg::ST_RX_IDLE]  <= 1'b0;
        rx_flags_reg[uart_pkg::ST_RX_AVAIL] <= rx_flags_reg[uart_pkg::ST_RX_AVAIL]
                                               | rx_evt_i.avail;
        rx_idle_reg  <= ~rx_evt_i.busy;
        rx_line_reg  <= rxtx_i;
      end
    end
  end

  // ==========================================================
  // Transmit shifter
  // Shifter has no address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 9'h000;
      cnt_reg      <= 4'h0;
      line_reg     <= 1'b1;
      oe_reg       <= 1'b0;
    end else if (ce_i) begin
      oe_reg <= tx_on;
      if (!tx_on) begin
        tx_state_reg <= TX_IDLE;
        tx_shift_reg <= 9'h000;
        cnt_reg      <= 4'h0;
        line_reg     <= 1'b1;
      end else begin
        unique case (tx_state_reg)
          TX_IDLE: begin
            if (buf_full_reg) begin
              tx_shift_reg <= frame_word(buf_reg, ninth_reg, fmt_reg);
              line_reg     <= 1'b0;
              cnt_reg      <= 4'h0;
              tx_state_reg <= TX_START;
            end
          end
          TX_START: begin
            if (bit_end) begin
              line_reg     <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
              tx_state_reg <= TX_BITS;
            end
          end
          TX_BITS: begin
            if (bit_end) begin
              if (cnt_reg == nbits - 4'h1) begin
                line_reg     <= 1'b1;
                cnt_reg      <= 4'h0;
                tx_state_reg <= TX_STOP;
              end else begin
                line_reg     <= tx_shift_reg[0];
                tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                cnt_reg      <= cnt_reg + 4'h1;
              end
            end
          end
          TX_STOP: begin
            if (bit_end) begin
              if (fmt_reg.stop2 && cnt_reg == 4'h0) begin
                cnt_reg <= 4'h1;
              end else begin
                tx_state_reg <= TX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign frame_done = tx_on && tx_state_reg == TX_STOP && bit_end
                      && !(fmt_reg.stop2 && cnt_reg == 4'h0);

  // ==========================================================
  // Pins
  // Drive transmit pin, idle high
  assign tx_pin_o    = line_reg;
  assign tx_pin_oe_o = oe_reg;
  assign rxtx_o      = line_reg;
  assign rxtx_oe_o   = oe_reg & single_wire_reg & ~rx_en_reg;
  assign rx_line_o   = rx_line_reg;

endmodule : uart_core

// ### uart_core_assertions.sv
// Purpose: Port checker for the serial port core
// Assumes: ce_i held high by the bench
// Notes:   Bound to every uart_core instance
module uart_core_checker #(
  parameter int DIV_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] readdata_o,
  input  wire logic        waitrequest_o,
  input  wire logic        tx_pin_o,
  input  wire logic        tx_pin_oe_o,
  input  wire logic        rxtx_oe_o,
  input  wire logic        rx_line_o
);
  // ==========================================================
  // Helpers
  logic [15:0] low_cnt;
  logic        acc_wr;
  assign acc_wr = write_i && !waitrequest_o && byteenable_i[0];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= 16'h0000;
    end else if (!tx_pin_o) begin
      low_cnt <= low_cnt + 16'h0001;
    end else begin
      low_cnt <= 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Properties
  sequence s_ack;
    waitrequest_o ##1 !waitrequest_o;
  endsequence
  sequence s_off;
    ##[1:2] (!tx_pin_oe_o && tx_pin_o && !rxtx_oe_o && rx_line_o);
  endsequence
  property p_ack;
    $rose(read_i || write_i) |-> s_ack;
  endproperty
  property p_unmap;
    read_i && !waitrequest_o && address_i >= 5'h18 |-> readdata_o == 32'h00000000;
  endproperty
  property p_idle;
    !tx_pin_oe_o |-> tx_pin_o;
  endproperty
  property p_start;
    $fell(tx_pin_o) |-> tx_pin_oe_o;
  endproperty
  property p_bit;
    $rose(tx_pin_o) && tx_pin_oe_o |-> low_cnt[3:0] == 4'h0 && low_cnt != 16'h0000;
  endproperty
  property p_mdis;
    acc_wr && address_i == uart_pkg::CTRL_ONE_OFS && !writedata_i[uart_pkg::MASTER_EN_BIT]
      |-> s_off;
  endproperty
  property p_tdis;
    acc_wr && address_i == uart_pkg::CTRL_TWO_OFS && !writedata_i[uart_pkg::TX_EN_BIT]
      |-> ##[1:2] (!tx_pin_oe_o && tx_pin_o);
  endproperty
  property p_swo;
    rxtx_oe_o |-> tx_pin_oe_o;
  endproperty
  a_ack: assert property (p_ack) else $error("Bus answer timing wrong");
  a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
  a_idle: assert property (p_idle) else $error("Released line not high");
  a_start: assert property (p_start) else $error("Start while not driving");
  a_bit: assert property (p_bit) else $error("Low run not whole bits");
  a_mdis: assert property (p_mdis) else $error("Pins kept after disable");
  a_tdis: assert property (p_tdis) else $error("Pin kept after tx off");
  a_swo: assert property (p_swo) else $error("Shared pin driven alone");
endmodule : uart_core_checker

bind uart_core uart_core_checker #(.DIV_W(DIV_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .tx_pin_o(tx_pin_o),
  .tx_pin_oe_o(tx_pin_oe_o), .rxtx_oe_o(rxtx_oe_o), .rx_line_o(rx_line_o));

// ### uart_pkg.sv
// Purpose: Shared constants and types for the serial port core
// Assumes: 32-bit Avalon-MM slave, byte addressed, one register per word
// Notes:   Eight-bit registers sit in the low byte, upper bits read zero
package uart_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [4:0] CTRL_ONE_OFS   = 5'h00;
  localparam logic [4:0] CTRL_TWO_OFS   = 5'h04;
  localparam logic [4:0] CTRL_THREE_OFS = 5'h08;
  localparam logic [4:0] DIVISOR_OFS    = 5'h0c;
  localparam logic [4:0] DATA_OFS       = 5'h10;
  localparam logic [4:0] STATUS_OFS     = 5'h14;

  // ==========================================================
  // Field positions, ctrl_reg_one
  localparam int MASTER_EN_BIT = 7;
  localparam int WORD_LEN_BIT  = 6;
  localparam int PAR_EN_BIT    = 5;
  localparam int PAR_TYPE_BIT  = 4;
  localparam int STOP_CNT_BIT  = 3;
  localparam int BREAK_BIT     = 2;
  localparam int NINTH_BIT     = 0;
  // Field positions, ctrl_reg_two
  localparam int TX_EN_BIT     = 7;
  localparam int RX_EN_BIT     = 6;
  localparam int HIGH_SPD_BIT  = 5;
  localparam int ADDR_EN_BIT   = 4;
  // Field positions, ctrl_reg_three
  localparam int SINGLE_WIRE_BIT = 0;
  // Field positions, port_status_reg
  localparam int ST_PARITY  = 0;
  localparam int ST_NOISE   = 1;
  localparam int ST_FRAMING = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_RX_IDLE = 4;
  localparam int ST_RX_AVAIL = 5;
  localparam int ST_TX_IDLE = 6;
  localparam int ST_TX_EMPTY = 7;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] DIVISOR_RST  = 8'h00;
  localparam logic       FLAG_SET_RST = 1'b1;
  localparam logic [5:0] SUB_LOW_MAX  = 6'h3f;
  localparam logic [5:0] SUB_HIGH_MAX = 6'h0f;
  localparam logic [3:0] BITS_NINE    = 4'h9;
  localparam logic [3:0] BITS_EIGHT   = 4'h8;

  // ==========================================================
  // Types
  typedef struct packed {
    logic word9;
    logic par_en;
    logic par_odd;
    logic stop2;
    logic addr_en;
  } fmt_s;

  typedef struct packed {
    logic busy;
    logic avail;
    logic overrun;
    logic framing;
    logic parity;
    logic noise;
  } rx_evt_s;

endpackage : uart_pkg
